/* File: include/cchv_pkg.sv */
// Constants and types shared by the cold cathode high voltage interlock
`default_nettype none
package cchv_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam longint unsigned CLK_HZ = 200_000_000;
    localparam longint unsigned CONV_FAST_MS = 50;
    localparam longint unsigned CONV_SLOW_MS = 100;
    localparam longint unsigned PAUSE_MAX_MS = 1000;
    localparam longint unsigned DELAY_SHORT_S = 3;
    localparam longint unsigned DELAY_LONG_S = 30;
    localparam longint unsigned CONV_FAST_CYC = CONV_FAST_MS * CLK_HZ / 1000;
    localparam longint unsigned CONV_SLOW_CYC = CONV_SLOW_MS * CLK_HZ / 1000;
    // Pause ends strictly before one second
    localparam longint unsigned PAUSE_MAX_CYC = PAUSE_MAX_MS * CLK_HZ / 1000 - 1;
    localparam longint unsigned DELAY_SHORT_CYC = DELAY_SHORT_S * CLK_HZ;
    localparam longint unsigned DELAY_LONG_CYC = DELAY_LONG_S * CLK_HZ;
    localparam int TMR_W = 28;
    localparam int DLY_W = 33;

    // ****************************************
    // Log pressure codes, 0.6 V per decade
    // ****************************************
    localparam int MV_W = 14;
    localparam logic [13:0] PROT_MIN_MV = 14'h1068;      // 1e-5 Torr
    localparam logic [13:0] PROT_MAX_MV = 14'h1770;      // 1e-2 Torr
    localparam logic [13:0] CTL_MAX_MV = 14'h1c12;       // 0.95 Torr
    localparam logic [13:0] CTL_MIN_THERMAL_MV = 14'h15cd; // 2e-3 Torr
    localparam logic [13:0] CTL_MIN_CAP1_MV = 14'h16bb;  // 0.5 % of 1 Torr
    localparam logic [13:0] CTL_MIN_CAP10_MV = 14'h1913; // 0.5 % of 10 Torr
    localparam logic [13:0] CTL_MIN_CAP100_MV = 14'h1b6b; // 0.5 % of 100 Torr
    localparam logic [13:0] LOG_OFF_MV = 14'h2710;       // Output off level

    // ****************************************
    // Channel layout
    // ****************************************
    localparam logic [2:0] CHAN_SLOT0 = 3'h0;
    localparam logic [2:0] CHAN_SLOT1 = 3'h1;
    localparam logic [2:0] CHAN_CTL0 = 3'h3;
    localparam logic [2:0] CHAN_CTL1 = 3'h4;

    typedef enum logic [2:0] {
        SENS_NONE = 3'b000,
        SENS_THERMAL = 3'b001,
        SENS_CAP1 = 3'b010,
        SENS_CAP10 = 3'b011,
        SENS_CAP100 = 3'b100,
        SENS_CAP_OTHER = 3'b101,
        SENS_COLD_CATH = 3'b110
    } cchv_sens_e;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_ON = 2'b01,
        ST_PROT = 2'b10,
        ST_CTL = 2'b11
    } cchv_state_e;
endpackage : cchv_pkg
`default_nettype wire

/* File: hw/cchv_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cchv_sync
    import cchv_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } cchv_sync_s;

    cchv_sync_s st_q;
    cchv_sync_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // Bit changes once last two stages agree
        for (int i = 0; i < WIDTH; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.lvl[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.lvl;
endmodule : cchv_sync
`default_nettype wire

/* File: hw/cchv_scan.sv */
// Conversion scan sequencer with bounded pause
`timescale 1ns/1ps
`default_nettype none
module cchv_scan
    import cchv_pkg::*;
#(
    parameter longint unsigned FAST_CYC = CONV_FAST_CYC,
    parameter longint unsigned SLOW_CYC = CONV_SLOW_CYC,
    parameter longint unsigned PAUSE_CYC = PAUSE_MAX_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic slow_mode,
    input wire logic pause_req,
    input wire logic [2:0] n_active,
    output logic conv_done,
    output logic [2:0] conv_chan,
    output logic paused
);
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic [TMR_W-1:0] pcnt;
        logic [2:0] chan;
        logic done;
        logic paused;
    } cchv_scan_s;

    cchv_scan_s st_q;
    cchv_scan_s st_d;
    logic [TMR_W-1:0] period;
    logic [2:0] last_chan;

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        period = slow_mode ? TMR_W'(SLOW_CYC - 1) : TMR_W'(FAST_CYC - 1);
        last_chan = (n_active == 3'h0) ? 3'h0 : n_active - 3'h1;
        if (!pause_req) begin
            st_d.pcnt = '0;
        end else if (st_q.pcnt != TMR_W'(PAUSE_CYC)) begin
            st_d.pcnt = st_q.pcnt + TMR_W'(1);
        end
        // Stuck pause overridden before one second
        st_d.paused = pause_req && (st_d.pcnt != TMR_W'(PAUSE_CYC));
        if (!st_d.paused) begin
            if (st_q.cnt >= period) begin
                st_d.cnt = '0;
                st_d.done = 1'b1;
                st_d.chan = (st_q.chan >= last_chan) ? 3'h0 : st_q.chan + 3'h1;
            end else begin
                st_d.cnt = st_q.cnt + TMR_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign conv_done = st_q.done;
    assign conv_chan = st_q.chan;
    assign paused = st_q.paused;
endmodule : cchv_scan
`default_nettype wire

/* File: hw/cchv_interlock.sv */
// Cold cathode high voltage interlock: protection and control shutdown
//
// Behaviour
// - Protection trip disables HV, latches indication in pressure mode
// - Protection trip needs off then on
// - Control exceed disables HV, shows indication in pressure mode
// - Control drop below restarts HV automatically
// - Auto restart after control shutdown or when remote disable pin clears
// - Power-up off; control needs first on
// - Control only for slot 0/1 sensor
// - Only thermal or 1/10/100 Torr heads qualify
// - Thermal control sensor fault shuts down
// - No control when third slot has cathode
// - Protection threshold clamped 1e-5 to 1e-2
// - Control threshold clamped by sensor type
// - Protection latch blocks control restart
// - Pressure/leak modes: 50 ms per sensor
// - Other modes: 100 ms per sensor
// - Scan pauses end under one second
// - Log output holds during pauses
// - Relay and buffered output never pause
// - Host disable cleared only by host enable
// - Outputs off, relay suppressed after turn-on
`timescale 1ns/1ps
`default_nettype none
module cchv_interlock
    import cchv_pkg::*;
#(
    parameter longint unsigned FAST_CYC = CONV_FAST_CYC,
    parameter longint unsigned SLOW_CYC = CONV_SLOW_CYC,
    parameter longint unsigned PAUSE_CYC = PAUSE_MAX_CYC,
    parameter longint unsigned DLY_SHORT_CYC = DELAY_SHORT_CYC,
    parameter longint unsigned DLY_LONG_CYC = DELAY_LONG_CYC,
    parameter logic [13:0] CTL_THERMAL_MIN = CTL_MIN_THERMAL_MV
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic op_on_cmd,
    input wire logic op_off_cmd,
    input wire logic host_hv_enable_cmd,
    input wire logic host_hv_disable_cmd,
    input wire logic remote_disable_pin,
    input wire logic ctl_fault_pin,
    input wire logic cc_slot_b,
    input wire logic ctl_chan_sel,
    input wire logic [2:0] ctl_type0,
    input wire logic [2:0] ctl_type1,
    input wire logic pressure_mode,
    input wire logic leak_mode,
    input wire logic scan_pause_req,
    input wire logic [2:0] n_active,
    input wire logic delay_long,
    input wire logic prot_enable,
    input wire logic [13:0] prot_setpt_mv,
    input wire logic ctl_enable,
    input wire logic [13:0] ctl_setpt_mv,
    input wire logic [13:0] relay_setpt_mv,
    input wire logic [13:0] adc_mv,
    input wire logic [13:0] cc_live_mv,
    output logic hv_enable,
    output logic protection_trip_indication,
    output logic control_shutdown_indication,
    output logic ctl_available,
    output logic cc_outputs_off,
    output logic cc_relay_active,
    output logic [13:0] cc_log_mv,
    output logic [13:0] cc_buffered_mv,
    output logic conv_done,
    output logic [2:0] conv_chan,
    output logic scan_paused
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        cchv_state_e state;
        logic host_dis;
        logic hv;
        logic prot_ind;
        logic ctl_ind;
        logic ctl_avail;
        logic outs_off;
        logic relay;
        logic [DLY_W-1:0] dly;
        logic [13:0] cc_samp;
        logic [13:0] ctl_samp;
        logic [13:0] cc_log;
        logic [13:0] cc_buf;
    } cchv_ilk_s;

    cchv_ilk_s st_q;
    cchv_ilk_s st_d;

    logic [1:0] pins_sync;
    logic remote_dis;
    logic ctl_fault;
    logic slow_mode;
    logic [2:0] cc_chan;
    logic [2:0] ctl_chan;
    cchv_sens_e ctl_type;
    logic ctl_qual;
    logic ctl_ok;
    logic [13:0] prot_thr;
    logic [13:0] ctl_thr;
    logic [13:0] ctl_min;
    logic prot_exceed;
    logic ctl_exceed;
    logic ctl_below;
    logic off_req;
    logic on_req;

    // ****************************************
    // Pins and scan
    // ****************************************
    cchv_sync #(
        .WIDTH(2)
    ) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .pin_in({ctl_fault_pin, remote_disable_pin}),
        .level_out(pins_sync)
    );

    assign remote_dis = pins_sync[0];
    assign ctl_fault = pins_sync[1];
    assign slow_mode = !(pressure_mode || leak_mode);

    cchv_scan #(
        .FAST_CYC(FAST_CYC),
        .SLOW_CYC(SLOW_CYC),
        .PAUSE_CYC(PAUSE_CYC)
    ) u_scan (
        .core_clk(core_clk),
        .reset(reset),
        .slow_mode(slow_mode),
        .pause_req(scan_pause_req),
        .n_active(n_active),
        .conv_done(conv_done),
        .conv_chan(conv_chan),
        .paused(scan_paused)
    );

    // ****************************************
    // Threshold qualification
    // ****************************************
    always_comb begin
        cc_chan = cc_slot_b ? CHAN_SLOT1 : CHAN_SLOT0;
        ctl_chan = ctl_chan_sel ? CHAN_CTL1 : CHAN_CTL0;
        ctl_type = cchv_sens_e'(ctl_chan_sel ? ctl_type1 : ctl_type0);
        case (ctl_type)
            SENS_THERMAL: ctl_min = CTL_THERMAL_MIN;
            SENS_CAP1: ctl_min = CTL_MIN_CAP1_MV;
            SENS_CAP10: ctl_min = CTL_MIN_CAP10_MV;
            SENS_CAP100: ctl_min = CTL_MIN_CAP100_MV;
            default: ctl_min = CTL_MAX_MV;
        endcase
        ctl_qual = (ctl_type == SENS_THERMAL) || (ctl_type == SENS_CAP1)
            || (ctl_type == SENS_CAP10) || (ctl_type == SENS_CAP100);
        // Cathode in third slot removes control
        ctl_ok = ctl_enable && ctl_qual
            && (ctl_type0 != SENS_COLD_CATH) && (ctl_type1 != SENS_COLD_CATH);
        if (prot_setpt_mv < PROT_MIN_MV) begin
            prot_thr = PROT_MIN_MV;
        end else if (prot_setpt_mv > PROT_MAX_MV) begin
            prot_thr = PROT_MAX_MV;
        end else begin
            prot_thr = prot_setpt_mv;
        end
        if (ctl_setpt_mv < ctl_min) begin
            ctl_thr = ctl_min;
        end else if (ctl_setpt_mv > CTL_MAX_MV) begin
            ctl_thr = CTL_MAX_MV;
        end else begin
            ctl_thr = ctl_setpt_mv;
        end
        // Reading invalid during start delay
        prot_exceed = prot_enable && st_q.hv && !st_q.outs_off
            && (st_q.cc_samp > prot_thr);
        ctl_exceed = ctl_ok && (((ctl_type == SENS_THERMAL) && ctl_fault)
            || (st_q.ctl_samp > ctl_thr));
        ctl_below = ctl_ok && !((ctl_type == SENS_THERMAL) && ctl_fault)
            && (st_q.ctl_samp < ctl_thr);
        off_req = op_off_cmd || host_hv_disable_cmd;
        on_req = op_on_cmd || host_hv_enable_cmd;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        if (host_hv_disable_cmd) begin
            st_d.host_dis = 1'b1;
        end else if (host_hv_enable_cmd) begin
            st_d.host_dis = 1'b0;
        end
        // Off beats on when both arrive together
        if (off_req) begin
            st_d.state = ST_OFF;
        end else begin
            case (st_q.state)
                ST_OFF: begin
                    if (on_req) begin
                        st_d.state = ST_ON;
                    end
                end
                ST_ON: begin
                    if (prot_exceed) begin
                        st_d.state = ST_PROT;
                    end else if (ctl_exceed) begin
                        st_d.state = ST_CTL;
                    end
                end
                ST_PROT: begin
                    st_d.state = ST_PROT;
                end
                ST_CTL: begin
                    if (ctl_below) begin
                        st_d.state = ST_ON;
                    end
                end
                default: begin
                    st_d.state = ST_OFF;
                end
            endcase
        end
        st_d.hv = (st_d.state == ST_ON) && !remote_dis && !st_d.host_dis;
        // Start delay on each HV turn-on
        if (st_d.hv && !st_q.hv) begin
            st_d.dly = delay_long ? DLY_W'(DLY_LONG_CYC) : DLY_W'(DLY_SHORT_CYC);
        end else if (!st_d.hv) begin
            st_d.dly = '0;
        end else if (st_q.dly != '0) begin
            st_d.dly = st_q.dly - DLY_W'(1);
        end
        st_d.outs_off = !st_d.hv || (st_d.dly != '0);
        if (conv_done && (conv_chan == cc_chan)) begin
            st_d.cc_samp = adc_mv;
        end
        if (conv_done && (conv_chan == ctl_chan)) begin
            st_d.ctl_samp = adc_mv;
        end
        // Log output goes to off level while outputs off, else moves only on a fresh conversion
        if (st_d.outs_off) begin
            st_d.cc_log = LOG_OFF_MV;
        end else if (conv_done && (conv_chan == cc_chan)) begin
            st_d.cc_log = adc_mv;
        end
        // Live path, independent of the scan
        st_d.cc_buf = st_d.outs_off ? LOG_OFF_MV : cc_live_mv;
        st_d.relay = !st_d.outs_off && (cc_live_mv < relay_setpt_mv);
        st_d.prot_ind = (st_d.state == ST_PROT) && pressure_mode;
        st_d.ctl_ind = (st_d.state == ST_CTL) && pressure_mode;
        st_d.ctl_avail = ctl_ok;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
            st_q.state <= ST_OFF;
            st_q.outs_off <= 1'b1;
            st_q.cc_log <= LOG_OFF_MV;
            st_q.cc_buf <= LOG_OFF_MV;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign hv_enable = st_q.hv;
    assign protection_trip_indication = st_q.prot_ind;
    assign control_shutdown_indication = st_q.ctl_ind;
    assign ctl_available = st_q.ctl_avail;
    assign cc_outputs_off = st_q.outs_off;
    assign cc_relay_active = st_q.relay;
    assign cc_log_mv = st_q.cc_log;
    assign cc_buffered_mv = st_q.cc_buf;
endmodule : cchv_interlock
`default_nettype wire

/* File: sim/cchv_sensor_model.sv */
// Behavioural high voltage supply and sensor set behind the interlock
`timescale 1ns/1ps
`default_nettype none
module cchv_sensor_model
    import cchv_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hv_enable,
    input wire logic [2:0] conv_chan,
    input wire logic [13:0] cath_p,
    input wire logic [13:0] ref_p,
    input wire logic fail,
    output logic [13:0] adc_mv,
    output logic [13:0] cc_live_mv,
    output logic ctl_fault_pin
);
    // ****************************************
    // Sensors
    // ****************************************
    logic [13:0] junk_q;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            junk_q <= 14'h0a5a;
        end else begin
            junk_q <= ~junk_q + 14'h0001;
        end
    end
    // Off level without high voltage
    assign cc_live_mv = hv_enable ? cath_p : LOG_OFF_MV;
    // Junk on unused channels
    assign adc_mv = (conv_chan == CHAN_SLOT0) ? cc_live_mv :
        (conv_chan == CHAN_CTL0 || conv_chan == CHAN_CTL1) ? (fail ? LOG_OFF_MV : ref_p) : junk_q;
    assign ctl_fault_pin = fail;
endmodule : cchv_sensor_model
`default_nettype wire

/* File: sim/cchv_interlock_assertions.sv */
// Port checker for the cold cathode high voltage interlock
`timescale 1ns/1ps
`default_nettype none
module cchv_interlock_assertions
    import cchv_pkg::*;
#(
    parameter longint unsigned FAST_CYC = 20,
    parameter longint unsigned SLOW_CYC = 40,
    parameter longint unsigned PAUSE_CYC = 100
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic op_on_cmd,
    input wire logic op_off_cmd,
    input wire logic host_hv_enable_cmd,
    input wire logic host_hv_disable_cmd,
    input wire logic remote_disable_pin,
    input wire logic ctl_chan_sel,
    input wire logic [2:0] ctl_type0,
    input wire logic [2:0] ctl_type1,
    input wire logic pressure_mode,
    input wire logic leak_mode,
    input wire logic scan_pause_req,
    input wire logic [13:0] relay_setpt_mv,
    input wire logic [13:0] cc_live_mv,
    input wire logic hv_enable,
    input wire logic protection_trip_indication,
    input wire logic control_shutdown_indication,
    input wire logic ctl_available,
    input wire logic cc_outputs_off,
    input wire logic cc_relay_active,
    input wire logic [13:0] cc_log_mv,
    input wire logic [13:0] cc_buffered_mv,
    input wire logic conv_done,
    input wire logic scan_paused
);
    // ****************************************
    // Helper state
    // ****************************************
    logic [15:0] gap_q, pc_q;
    logic [3:0] rc_q;
    logic seen_q, pz_q, md_q, hd_q;
    wire logic fast = pressure_mode | leak_mode;
    wire logic [2:0] st = ctl_chan_sel ? ctl_type1 : ctl_type0;
    wire logic q_ok = st >= SENS_THERMAL && st <= SENS_CAP100 &&
        ctl_type0 != SENS_COLD_CATH && ctl_type1 != SENS_COLD_CATH;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            {gap_q, pc_q, rc_q, seen_q, pz_q, md_q, hd_q} <= '0;
        end else begin
            gap_q <= conv_done ? 16'h0000 : gap_q + 16'h0001;
            seen_q <= seen_q | conv_done;
            md_q <= conv_done ? fast : md_q;
            // Pause or mode change spoils interval
            pz_q <= conv_done ? (scan_pause_req | scan_paused) :
                (pz_q | scan_pause_req | scan_paused | (fast != md_q));
            pc_q <= scan_paused ? pc_q + 16'h0001 : 16'h0000;
            rc_q <= remote_disable_pin ? 4'hf : rc_q - {3'h0, rc_q != 4'h0};
            hd_q <= host_hv_disable_cmd | (hd_q & ~host_hv_enable_cmd);
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_held_off;
        cc_outputs_off [*8];
    endsequence
    a_off_cmd_drops: assert property ((op_off_cmd || host_hv_disable_cmd) |=> !hv_enable)
        else $error("hv on after off");
    a_host_dis_holds: assert property (hd_q |-> !hv_enable)
        else $error("hv on under host disable");
    a_prot_kills_hv: assert property (protection_trip_indication |-> !hv_enable)
        else $error("hv on in protection trip");
    a_ctl_kills_hv: assert property (control_shutdown_indication |-> !hv_enable)
        else $error("hv on in control shutdown");
    a_rise_has_cause: assert property ($rose(hv_enable) |->
        $past(op_on_cmd || host_hv_enable_cmd) || ctl_available || rc_q != 4'h0)
        else $error("hv rose without cause");
    a_start_delay: assert property ($rose(hv_enable) |-> s_held_off)
        else $error("outputs released early");
    a_conv_period: assert property (conv_done && seen_q && !pz_q && fast == md_q |->
        gap_q == (fast ? 16'(FAST_CYC - 1) : 16'(SLOW_CYC - 1)))
        else $error("conversion period wrong");
    a_pause_bound: assert property (scan_paused |-> pc_q <= 16'(PAUSE_CYC))
        else $error("scan pause too long");
    a_log_holds: assert property (scan_paused && $past(scan_paused) && $stable(cc_outputs_off)
        |-> $stable(cc_log_mv))
        else $error("log moved in pause");
    a_buf_follows: assert property (!$past(cc_outputs_off) && !cc_outputs_off |->
        cc_buffered_mv == $past(cc_live_mv))
        else $error("buffered not live");
    a_relay_follows: assert property (!$past(cc_outputs_off) && !cc_outputs_off |->
        cc_relay_active == ($past(cc_live_mv) < $past(relay_setpt_mv)))
        else $error("relay not live");
    a_ctl_avail_gate: assert property (!q_ok && !$past(q_ok) |-> !ctl_available)
        else $error("control available unqualified");
endmodule : cchv_interlock_assertions
bind cchv_interlock cchv_interlock_assertions #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC),
    .PAUSE_CYC(PAUSE_CYC)) chk_i (.*);
`default_nettype wire

/* File: sim/cchv_interlock_tb_top.sv */
// Self-checking bench for the cold cathode high voltage interlock
`timescale 1ns/1ps
`default_nettype none
module cchv_interlock_tb_top
    import cchv_pkg::*;
;
    logic core_clk = 1'h0, reset = 1'h1, op_on_cmd = 1'h0, op_off_cmd = 1'h0;
    logic host_hv_enable_cmd = 1'h0, host_hv_disable_cmd = 1'h0, remote_disable_pin = 1'h0;
    logic cc_slot_b = 1'h0, ctl_chan_sel = 1'h1, pressure_mode = 1'h1, leak_mode = 1'h0;
    logic scan_pause_req = 1'h0, delay_long = 1'h0, prot_enable = 1'h0, ctl_enable = 1'h1;
    logic fail = 1'h0;
    logic [2:0] ctl_type0 = 3'h0, ctl_type1 = 3'h1, n_active = 3'h5;
    logic [13:0] prot_setpt_mv = 14'h1400, ctl_setpt_mv = 14'h1800, relay_setpt_mv = 14'h1000;
    logic [13:0] cath_p = 14'h0c00, ref_p = 14'h1600, lg;
    logic hv_enable, protection_trip_indication, control_shutdown_indication, ctl_available;
    logic cc_outputs_off, cc_relay_active, conv_done, scan_paused, ctl_fault_pin;
    logic [13:0] cc_log_mv, cc_buffered_mv, adc_mv, cc_live_mv;
    logic [2:0] conv_chan;
    logic [31:0] seed = 32'h00016ce9;
    int miscompares = 0, n_tests = 0, n;
    always #2.5 core_clk = ~core_clk;
    cchv_interlock #(.FAST_CYC(20), .SLOW_CYC(40), .PAUSE_CYC(100), .DLY_SHORT_CYC(10),
        .DLY_LONG_CYC(30)) uut (.*);
    cchv_sensor_model model_i (.*);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    function automatic logic exp_avail(input logic [2:0] t);
        return t >= SENS_THERMAL && t <= SENS_CAP100;
    endfunction : exp_avail
    function automatic int exp_period(input logic fast);
        return fast ? 20 : 40;
    endfunction : exp_period
    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk1
    task automatic chk14(input string nm, input logic [13:0] e, input logic [13:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk14
    task automatic settle(input int c);
        repeat (c) @(negedge core_clk);
    endtask : settle
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(negedge core_clk);
        s = 1'h0;
    endtask : pulse
    task automatic wait_hv(input logic v, input int lim);
        for (int i = 0; i < lim && hv_enable !== v; i++) @(negedge core_clk);
    endtask : wait_hv
    task automatic gap(output int c);
        for (int i = 0; i < 200 && conv_done !== 1'h1; i++) @(negedge core_clk);
        @(negedge core_clk);
        for (c = 1; c < 200 && conv_done !== 1'h1; c++) @(negedge core_clk);
    endtask : gap
    task automatic summarize();
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        summarize();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        settle(16);
        reset = 1'h0;
        chk1("hv_enable", 1'h0, hv_enable);
        chk14("cc_log_mv", LOG_OFF_MV, cc_log_mv);
        ref_p = 14'h1a00; // No start before first on
        settle(150);
        ref_p = 14'h1600;
        settle(150);
        chk1("hv_enable", 1'h0, hv_enable);
        pulse(op_on_cmd);
        chk1("hv_enable", 1'h1, hv_enable);
        chk1("cc_outputs_off", 1'h1, cc_outputs_off);
        settle(15);
        chk1("cc_outputs_off", 1'h0, cc_outputs_off);
        chk1("cc_relay_active", 1'h1, cc_relay_active);
        ref_p = 14'h1a00;
        wait_hv(1'h0, 250);
        chk1("hv_enable", 1'h0, hv_enable);
        chk1("control_shutdown_indication", 1'h1, control_shutdown_indication);
        chk1("ctl_available", 1'h1, ctl_available);
        ref_p = 14'h1600;
        wait_hv(1'h1, 250);
        chk1("hv_enable", 1'h1, hv_enable);
        fail = 1'h1;
        wait_hv(1'h0, 250);
        chk1("hv_enable", 1'h0, hv_enable);
        fail = 1'h0;
        wait_hv(1'h1, 250);
        settle(250); // Fresh cathode sample
        chk14("cc_log_mv", cath_p, cc_log_mv);
        prot_enable = 1'h1;
        cath_p = 14'h1500;
        wait_hv(1'h0, 250);
        chk1("hv_enable", 1'h0, hv_enable);
        chk1("protection_trip_indication", 1'h1, protection_trip_indication);
        prot_enable = 1'h0;
        cath_p = 14'h0c00;
        pulse(op_on_cmd);
        ref_p = 14'h1a00;
        settle(150);
        ref_p = 14'h1600;
        settle(150);
        chk1("hv_enable", 1'h0, hv_enable);
        pulse(op_off_cmd);
        pulse(op_on_cmd);
        chk1("hv_enable", 1'h1, hv_enable);
        settle(250);
        seed = xs(seed);
        cath_p = 14'h1000 + {8'h00, seed[5:0]};
        prot_setpt_mv = 14'h0100;
        prot_enable = 1'h1;
        settle(250);
        chk1("hv_enable", 1'h1, hv_enable);
        seed = xs(seed);
        cath_p = 14'h1780 + {6'h00, seed[7:0]};
        prot_setpt_mv = 14'h3000;
        wait_hv(1'h0, 250);
        chk1("hv_enable", 1'h0, hv_enable);
        prot_enable = 1'h0;
        cath_p = 14'h0c00;
        pulse(op_off_cmd);
        pulse(op_on_cmd);
        pulse(host_hv_disable_cmd);
        chk1("hv_enable", 1'h0, hv_enable);
        pulse(op_off_cmd);
        pulse(op_on_cmd);
        chk1("hv_enable", 1'h0, hv_enable);
        pulse(host_hv_enable_cmd);
        chk1("hv_enable", 1'h1, hv_enable);
        remote_disable_pin = 1'h1;
        settle(8);
        chk1("hv_enable", 1'h0, hv_enable);
        remote_disable_pin = 1'h0;
        settle(8);
        chk1("hv_enable", 1'h1, hv_enable);
        for (int t = 0; t < 7; t++) begin
            ctl_type1 = 3'(t);
            settle(4);
            chk1("ctl_available", exp_avail(3'(t)), ctl_available);
        end
        ctl_type0 = SENS_COLD_CATH;
        ctl_type1 = SENS_THERMAL;
        settle(4);
        chk1("ctl_available", 1'h0, ctl_available);
        ctl_type0 = SENS_NONE;
        for (int m = 0; m < 3; m++) begin
            {pressure_mode, leak_mode} = 2'(2'h2 >> m);
            gap(n);
            chk1("conv_period", 1'h1, n == exp_period(m < 2));
        end
        pressure_mode = 1'h1;
        settle(20);
        scan_pause_req = 1'h1;
        settle(3);
        chk1("scan_paused", 1'h1, scan_paused);
        lg = cc_log_mv;
        seed = xs(seed);
        cath_p = 14'h0800 + {4'h0, seed[9:0]};
        settle(3);
        chk14("cc_buffered_mv", cath_p, cc_buffered_mv);
        chk14("cc_log_mv", lg, cc_log_mv);
        settle(100);
        chk1("scan_paused", 1'h0, scan_paused);
        scan_pause_req = 1'h0;
        summarize();
    end
endmodule : cchv_interlock_tb_top
`default_nettype wire
